// file: design/cmfg_pkg.sv
// Purpose: Constants and types for the clock selector and fanout block
// Assumes: Clock inputs and controls are sampled by clk_sys
// Notes: What this block does
package cmfg_pkg;

  localparam int CMFG_PAIRS = 5;
  localparam int CMFG_CLK_NS = 25;
  localparam int CMFG_STALL_NS = 1000;
  localparam int CMFG_STALL_CYC = (CMFG_STALL_NS / CMFG_CLK_NS < 1) ? 1 :
    CMFG_STALL_NS / CMFG_CLK_NS;
  localparam int CMFG_CNT_W = 8;
  localparam logic CMFG_EN_RST = 1'b0;
  localparam logic CMFG_SEL_DEFAULT = 1'b1;

  typedef struct packed {
    logic [CMFG_PAIRS-1:0] pos;
    logic [CMFG_PAIRS-1:0] neg;
  } cmfg_pairs_t;

  typedef enum logic [1:0] {
    CMFG_OFF = 2'b00,
    CMFG_WAIT_RISE = 2'b01,
    CMFG_WAIT_FALL = 2'b11
  } cmfg_state_t;

endpackage : cmfg_pkg

// file: design/cmfg_top.sv
// Purpose: Two-input clock selector with five gated differential copies
// Assumes: Pull-ups modelled by *_open flags; input pins are asynchronous
// Notes: Outputs come straight from flip-flops
`timescale 1ns/1ps
`default_nettype none
module cmfg_top
  import cmfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic first_clock_in,
  input wire logic first_clock_in_n,
  input wire logic first_clock_open,
  input wire logic second_clock_in,
  input wire logic second_clock_in_n,
  input wire logic second_clock_open,
  input wire logic source_select,
  input wire logic source_select_open,
  input wire logic output_enable,
  input wire logic output_enable_open,
  output cmfg_pairs_t fanout_pairs,
  output logic input_loss_guard
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] raw;

  always_comb
  begin
    raw[0] = first_clock_open ? 1'b0 : (first_clock_in & ~first_clock_in_n);
    raw[1] = second_clock_open ? 1'b0 :
      (second_clock_in & ~second_clock_in_n);
    raw[2] = source_select_open ? CMFG_SEL_DEFAULT : source_select;
    raw[3] = output_enable_open ? 1'b1 : output_enable;
    raw[4] = first_clock_open | (first_clock_in == first_clock_in_n);
    raw[5] = second_clock_open | (second_clock_in == second_clock_in_n);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source selection and edge detection
  logic sel_clk;
  logic sel_dead;
  logic prev_clk;
  logic rise;
  logic fall;

  always_comb
  begin
    sel_clk = sync2[2] ? sync2[1] : sync2[0];
    sel_dead = sync2[2] ? sync2[5] : sync2[4];
    rise = sel_clk & ~prev_clk;
    fall = ~sel_clk & prev_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Fail-safe guard
  logic [CMFG_CNT_W-1:0] idle_cnt;
  logic [CMFG_CNT_W-1:0] next_idle_cnt;
  logic next_guard;

  always_comb
  begin
    next_idle_cnt = idle_cnt;
    next_guard = input_loss_guard;
    if (rise | fall)
    begin
      next_idle_cnt = '0;
      // Invalid pair wins over the edge
      next_guard = sel_dead;
    end
    else if (idle_cnt >= CMFG_CNT_W'(CMFG_STALL_CYC) || sel_dead)
      next_guard = 1'b1;
    else
      next_idle_cnt = idle_cnt + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Synchronous enable sequencing
  cmfg_state_t state;
  cmfg_state_t next_state;
  logic gate_on;
  logic next_gate_on;
  cmfg_pairs_t next_pairs;
  logic out_level;

  always_comb
  begin
    next_state = state;
    next_gate_on = gate_on;
    unique case (state)
      CMFG_OFF:
        if (sync2[3] != gate_on)
          next_state = CMFG_WAIT_RISE;
      CMFG_WAIT_RISE:
        if (sync2[3] == gate_on)
          next_state = CMFG_OFF;
        else if (rise)
          next_state = CMFG_WAIT_FALL;
      CMFG_WAIT_FALL:
        if (sync2[3] == gate_on)
          next_state = CMFG_OFF;
        else if (fall)
        begin
          next_gate_on = sync2[3];
          next_state = CMFG_OFF;
        end
      default:
        next_state = CMFG_OFF;
    endcase
    out_level = input_loss_guard ? fanout_pairs.pos[0] : sel_clk;
    next_pairs.pos = {CMFG_PAIRS{next_gate_on & out_level}};
    next_pairs.neg = ~next_pairs.pos;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      prev_clk <= 1'b0;
      idle_cnt <= '0;
      input_loss_guard <= 1'b1;
      state <= CMFG_OFF;
      gate_on <= CMFG_EN_RST;
      fanout_pairs.pos <= '0;
      fanout_pairs.neg <= '1;
    end
    else
    begin
      prev_clk <= sel_clk;
      idle_cnt <= next_idle_cnt;
      input_loss_guard <= next_guard;
      state <= next_state;
      gate_on <= next_gate_on;
      fanout_pairs <= next_pairs;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  // disabled levels
  property p_off_levels;
    @(posedge clk_sys) disable iff (reset)
      !gate_on |=> (fanout_pairs.pos == '0 && fanout_pairs.neg == '1);
  endproperty
  a_off_levels: assert property (p_off_levels)
    else $error("Disabled outputs not parked");

  property p_copies;
    @(posedge clk_sys) disable iff (reset)
      (fanout_pairs.pos == '0 || fanout_pairs.pos == '1) &&
      fanout_pairs.neg == ~fanout_pairs.pos;
  endproperty
  a_copies: assert property (p_copies)
    else $error("Output pairs differ");

  // enable changes only on falling edge
  property p_en_on_fall;
    @(posedge clk_sys) disable iff (reset)
      (gate_on != $past(gate_on)) |-> $past(fall);
  endproperty
  a_en_on_fall: assert property (p_en_on_fall)
    else $error("Enable changed off a falling edge");

  property p_rise_first;
    @(posedge clk_sys) disable iff (reset)
      (state == CMFG_WAIT_FALL && $past(state) == CMFG_WAIT_RISE)
      |-> $past(rise);
  endproperty
  a_rise_first: assert property (p_rise_first)
    else $error("Fall wait without rise");

  property p_follow;
    @(posedge clk_sys) disable iff (reset)
      (next_gate_on && !input_loss_guard) |=>
      fanout_pairs.pos[0] == $past(sel_clk);
  endproperty
  a_follow: assert property (p_follow)
    else $error("Output not following selected input");

  property p_guard_hold;
    @(posedge clk_sys) disable iff (reset)
      (input_loss_guard && $past(input_loss_guard) && gate_on &&
      $past(gate_on)) |-> $stable(fanout_pairs.pos);
  endproperty
  a_guard_hold: assert property (p_guard_hold)
    else $error("Outputs toggled under guard");

  property p_stall;
    @(posedge clk_sys) disable iff (reset)
      idle_cnt >= CMFG_CNT_W'(CMFG_STALL_CYC) && !rise && !fall
      |=> input_loss_guard;
  endproperty
  a_stall: assert property (p_stall)
    else $error("Guard missed a stall");

  property p_req;
    @(posedge clk_sys) disable iff (reset)
      (state == CMFG_OFF && sync2[3] != gate_on) |=>
      state == CMFG_WAIT_RISE;
  endproperty
  a_req: assert property (p_req)
    else $error("Enable request not sequenced");

endmodule : cmfg_top
`default_nettype wire

// file: testbench/clock_mux_fanout_gate_bench.sv
// Purpose: Self-checking bench for the clock selector and fanout
// Assumes: Sources stop at DC to model a failed clock
// Notes: Toggle counts on the pairs tell which input is routed
`timescale 1ns/1ps
`default_nettype none
module clock_mux_fanout_gate_bench;
  import cmfg_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic run0 = 1'b0;
  logic run1 = 1'b0;
  logic sel = 1'b0;
  logic sel_open = 1'b0;
  logic oe = 1'b0;
  logic oe_open = 1'b0;
  logic open0 = 1'b0;
  logic open1 = 1'b0;
  wire logic c0, c0_n, c1, c1_n;
  cmfg_pairs_t pairs;
  logic guard;
  int num_errors = 0;
  int tests_run = 0;
  int flips;
  always #12.5 clk_sys = ~clk_sys;
  cmfg_src_model cmfg_src_model_inst0 (.run(run0), .clk_p(c0), .clk_n(c0_n));
  cmfg_src_model cmfg_src_model_inst1 (.run(run1), .clk_p(c1), .clk_n(c1_n));
  cmfg_top cmfg_top_inst (.clk_sys(clk_sys), .reset(reset),
    .first_clock_in(c0), .first_clock_in_n(c0_n), .first_clock_open(open0),
    .second_clock_in(c1), .second_clock_in_n(c1_n),
    .second_clock_open(open1), .source_select(sel),
    .source_select_open(sel_open), .output_enable(oe),
    .output_enable_open(oe_open), .fanout_pairs(pairs),
    .input_loss_guard(guard));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic watch(input int n, input logic moving);
    cmfg_pairs_t last;
    flips = 0;
    last = pairs;
    repeat (n)
    begin
      @(negedge clk_sys);
      check(pairs.neg, ~pairs.pos);
      check(pairs.pos, {5{pairs.pos[0]}});
      if (pairs !== last)
        flips++;
      last = pairs;
    end
    check(5'(flips > 0), 5'(moving));
  endtask : watch
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////
  task automatic t_enable;
    check(pairs.pos, 5'h00);
    check(pairs.neg, 5'h1f);
    @(negedge clk_sys);
    oe = 1'b1;
    watch(3, 1'b0);
    repeat (60) @(negedge clk_sys);
    watch(60, 1'b1);
    check(5'(guard), 5'h00);
    $display("done: enable on first input");
  endtask : t_enable
  task automatic t_select;
    sel_open = 1'b1;
    run0 = 1'b0;
    run1 = 1'b1;
    repeat (80) @(negedge clk_sys);
    watch(60, 1'b1);
    sel_open = 1'b0;
    repeat (60) @(negedge clk_sys);
    watch(60, 1'b0);
    check(5'(guard), 5'h01);
    sel = 1'b1;
    repeat (60) @(negedge clk_sys);
    watch(60, 1'b1);
    check(5'(guard), 5'h00);
    $display("done: source selection and stall guard");
  endtask : t_select
  task automatic t_open_input;
    open1 = 1'b1;
    repeat (8) @(negedge clk_sys);
    watch(60, 1'b0);
    check(5'(guard), 5'h01);
    open0 = 1'b1;
    sel = 1'b0;
    repeat (8) @(negedge clk_sys);
    watch(60, 1'b0);
    check(5'(guard), 5'h01);
    open0 = 1'b0;
    open1 = 1'b0;
    sel = 1'b1;
    repeat (20) @(negedge clk_sys);
    watch(20, 1'b1);
    check(5'(guard), 5'h00);
    $display("done: open clock inputs");
  endtask : t_open_input
  task automatic t_disable;
    oe = 1'b0;
    oe_open = 1'b1;
    repeat (40) @(negedge clk_sys);
    watch(60, 1'b1);
    oe_open = 1'b0;
    repeat (60) @(negedge clk_sys);
    watch(60, 1'b0);
    check(pairs.pos, 5'h00);
    check(pairs.neg, 5'h1f);
    $display("done: open enable and disable");
  endtask : t_disable
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    run0 = 1'b1;
    @(negedge clk_sys);
    t_enable();
    t_select();
    t_open_input();
    t_disable();
    finish_test();
  end
  initial
  begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule : clock_mux_fanout_gate_bench
`default_nettype wire

// file: testbench/cmfg_src_model.sv
// Purpose: Upstream differential clock source, 200 ns period
// Assumes: run high lets the clock toggle, low stops it at DC
// Notes: Phase offset keeps edges away from clk_sys edges
`timescale 1ns/1ps
`default_nettype none
module cmfg_src_model
(
  input wire logic run,
  output logic clk_p,
  output logic clk_n
);
  initial
  begin
    clk_p = 1'b0;
    #3;
    forever
    begin
      #100;
      if (run)
        clk_p = ~clk_p;
    end
  end
  assign clk_n = ~clk_p;
endmodule : cmfg_src_model
`default_nettype wire
